// ### logic/timer_cfg.svh
// offsets, field positions and reset values of the timer block
// Notes on behaviour
// - prescale_select picks divider or external clock
// - external clock pin forced input when selected
// - overflow_flag set on wrap after modulo
// - overflow_flag cleared by read then zero write
// - overflow request when flag and enable set
// - counter_stop freezes counter, set by reset
// - counter reset bit clears counter and prescaler
// - stop plus reset leaves counter at zero
// - high byte read latches low byte
// - counter equals modulo, then restarts at zero
// - modulo high write blocks overflow_flag until low
// - channel flag on capture edge or compare
// - channel flag cleared by read then zero write
// - channel request when flag and enable set
// - buffered bit on channels 0 and 2 only
// - mode bit a: capture/compare or initial level
// - toggle on overflow, overflow beats compare
// - high byte access blocks capture or compare
// - edge/level zero disconnects channel pin
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

`define AXI_AW       8
`define OFS_TSC      8'h00
`define OFS_CNT_HI   8'h04
`define OFS_CNT_LO   8'h08
`define OFS_MOD_HI   8'h0c
`define OFS_MOD_LO   8'h10
`define OFS_CH0_SC   8'h14
`define CH_STRIDE    8'h0c
`define CH_HI        8'h04
`define CH_LO        8'h08
`define OFS_LAST     8'h40

`define TSC_FLAG     7
`define TSC_IE       6
`define TSC_STOP     5
`define TSC_RST      4
`define CSC_FLAG     7

`define PS_EXT       3'h7
`define MOD_RST      16'hffff
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`define ELS_TOGGLE   2'h1
`define ELS_CLEAR    2'h2
`define ELS_SET      2'h3

`endif

// ### logic/timer_pkg.sv
// state types of the timer block
package timer_pkg;

	typedef struct packed {
		logic        aw_rdy, w_rdy, aw_got, w_got, wstrb0, bvalid;
		logic [7:0]  awaddr, wdata;
		logic [1:0]  bresp;
		logic        ar_rdy, rvalid;
		logic [7:0]  rdata;
		logic [1:0]  rresp;
		logic [2:0]  ps;
		logic        overflow_irq_enable, counter_stop, overflow_flag, tof_armed, mod_block, lo_held;
		logic [15:0] cnt, mod;
		logic [7:0]  lo_buf;
		logic [5:0]  presc;
		logic        ext_s1, ext_s2, ext_s3, step, ovf, ovf_irq, ext_force;
	} main_state_t;

	typedef struct packed {
		logic        flag, armed, ie, msb, msa, tov, max;
		logic [1:0]  els;
		logic [15:0] val;
		logic [7:0]  stage;
		logic        cap_block, cmp_block, pin_q, oe_q, irq_q, pin_prev;
		logic        sel, pend;
	} chan_state_t;

endpackage

// ### logic/chan_if.sv
// links the timer core to one capture/compare channel
`timescale 1ns/1ps
`default_nettype none
interface chan_if;
	logic        wr_sc, wr_hi, wr_lo, rd_sc, rd_hi, rd_lo;
	logic [7:0]  wdata;
	logic [15:0] cnt;
	logic        step, ovf, pin_in, linked_off, partner_wr;
	logic [15:0] partner_val;
	logic [7:0]  sc_rd, hi_rd, lo_rd;
	logic [15:0] val;
	logic        buf_on, pin_out, pin_oe, irq;

	modport ctrl (output wr_sc, wr_hi, wr_lo, rd_sc, rd_hi, rd_lo, wdata,
		cnt, step, ovf, pin_in, linked_off, partner_wr, partner_val,
		input sc_rd, hi_rd, lo_rd, val, buf_on, pin_out, pin_oe, irq);
	modport unit (input wr_sc, wr_hi, wr_lo, rd_sc, rd_hi, rd_lo, wdata,
		cnt, step, ovf, pin_in, linked_off, partner_wr, partner_val,
		output sc_rd, hi_rd, lo_rd, val, buf_on, pin_out, pin_oe, irq);
endinterface
`default_nettype wire

// ### logic/timer_channel.sv
// one capture/compare channel with flag, pin and value register
`timescale 1ns/1ps
`default_nettype none
`include "timer_cfg.svh"
module timer_channel #(
	parameter bit HAS_BUF = 1'b0
) (
	input  wire logic  aclk,
	input  wire logic  aresetn,
	chan_if.unit       bus
);
	import timer_pkg::*;

	chan_state_t s_reg;
	chan_state_t s_next;
	logic        out_mode;
	logic        cap_mode;
	logic        match;
	logic        edge_hit;
	logic [15:0] cmp_val;

	// odd channel of a linked pair shows an empty status register
	assign bus.sc_rd   = bus.linked_off ? 8'h00 : {s_reg.flag, s_reg.ie,
		s_reg.msb, s_reg.msa, s_reg.els, s_reg.tov, s_reg.max};
	assign bus.hi_rd   = s_reg.val[15:8];
	assign bus.lo_rd   = s_reg.val[7:0];
	assign bus.val     = s_reg.val;
	assign bus.buf_on  = s_reg.msb;
	assign bus.pin_out = s_reg.pin_q;
	assign bus.pin_oe  = s_reg.oe_q;
	assign bus.irq     = s_reg.irq_q;

	// mode decode; buffered bit or mode bit a selects output compare
	assign out_mode = s_reg.msb | s_reg.msa;
	assign cap_mode = ~out_mode & (s_reg.els != 2'h0);
	assign cmp_val  = (s_reg.msb & s_reg.sel) ? bus.partner_val : s_reg.val;
	assign match    = bus.step & (bus.cnt == cmp_val) & ~s_reg.cmp_block
		& out_mode & (s_reg.els != 2'h0);
	assign edge_hit = (s_reg.els[0] & bus.pin_in & ~s_reg.pin_prev)
		| (s_reg.els[1] & ~bus.pin_in & s_reg.pin_prev);

	// next state of the channel
	always_comb
	begin
		s_next = s_reg;
		s_next.pin_prev = bus.pin_in;
		if (bus.rd_sc & s_reg.flag)
			s_next.armed = 1'b1;
		if (bus.wr_sc & ~bus.linked_off)
		begin
			if (~bus.wdata[`CSC_FLAG] & s_reg.armed)
				s_next.flag = 1'b0;
			s_next.armed = 1'b0;
			s_next.ie    = bus.wdata[6];
			s_next.msb   = HAS_BUF & bus.wdata[5];
			s_next.msa   = bus.wdata[4];
			s_next.els   = bus.wdata[3:2];
			s_next.tov   = bus.wdata[1];
			s_next.max   = bus.wdata[0];
		end
		// high byte access holds off the other direction's event
		if (bus.rd_hi & cap_mode)
			s_next.cap_block = 1'b1;
		if (bus.rd_lo)
			s_next.cap_block = 1'b0;
		if (bus.wr_hi)
		begin
			s_next.stage     = bus.wdata;
			s_next.cmp_block = 1'b1;
		end
		if (bus.wr_lo)
		begin
			s_next.val       = {s_reg.stage, bus.wdata};
			s_next.cmp_block = 1'b0;
			s_next.pend      = 1'b0;
		end
		// buffered pair: the last written half takes over at overflow
		if (bus.partner_wr)
			s_next.pend = 1'b1;
		if (bus.ovf)
			s_next.sel = s_reg.msb & s_next.pend;
		// events win over a clear in the same cycle
		if (~bus.linked_off & cap_mode & ~s_reg.cap_block & edge_hit)
		begin
			s_next.val   = bus.cnt;
			s_next.flag  = 1'b1;
			s_next.armed = 1'b0;
		end
		if (~bus.linked_off & match)
		begin
			s_next.flag  = 1'b1;
			s_next.armed = 1'b0;
		end
		// pin level
		if (s_reg.els == 2'h0)
			s_next.pin_q = ~s_reg.msa;
		else if (out_mode)
		begin
			if (bus.ovf & s_reg.tov)
				s_next.pin_q = ~s_reg.pin_q;
			else if (match)
			begin
				case (s_reg.els)
					`ELS_TOGGLE: s_next.pin_q = ~s_reg.pin_q;
					`ELS_CLEAR:  s_next.pin_q = 1'b0;
					`ELS_SET:    s_next.pin_q = 1'b1;
					default:     s_next.pin_q = s_reg.pin_q;
				endcase
			end
			if (s_reg.max & ~s_reg.tov)
				s_next.pin_q = (s_reg.els == `ELS_CLEAR);
		end
		s_next.oe_q = out_mode & (s_next.els != 2'h0) & ~bus.linked_off
			& ~(s_next.els == 2'h0);
		s_next.irq_q = s_next.flag & s_next.ie & ~bus.linked_off;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_reg       <= '0;
			s_reg.pin_q <= 1'b1;
		end
		else
			s_reg <= s_next;
	end
endmodule
`default_nettype wire

// ### logic/timer_module.sv
// 16-bit modulo timer with four capture/compare channels, axi4-lite slave
`timescale 1ns/1ps
`default_nettype none
`include "timer_cfg.svh"
module timer_module (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [`AXI_AW-1:0] awaddr,
	input  wire logic [2:0]        awprot,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [`AXI_AW-1:0] araddr,
	input  wire logic [2:0]        arprot,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic              external_clock_pin,
	output logic                   external_clock_force_input,
	input  wire logic [3:0]        channel_pin_in,
	output logic [3:0]             channel_pin_out,
	output logic [3:0]             channel_pin_oe,
	output logic                   overflow_irq,
	output logic [3:0]             channel_irq
);
	import timer_pkg::*;

	main_state_t s_reg;
	main_state_t s_next;
	logic        wr_en;
	logic        wr_fire;
	logic        rd_fire;
	logic        tick;
	logic        wrap;
	logic        ext_rise;
	logic [5:0]  pmask;
	logic [7:0]  rmux;
	logic        rmapped;
	logic [7:0]  ch_sc [4];
	logic [7:0]  ch_hi [4];
	logic [7:0]  ch_lo [4];

	chan_if chan [4] ();

	// a write runs once both address and data are held
	assign wr_fire = s_reg.aw_got & s_reg.w_got & ~s_reg.bvalid;
	assign wr_en   = wr_fire & s_reg.wstrb0;
	assign rd_fire = arvalid & s_reg.ar_rdy;

	assign awready = s_reg.aw_rdy;
	assign wready  = s_reg.w_rdy;
	assign bvalid  = s_reg.bvalid;
	assign bresp   = s_reg.bresp;
	assign arready = s_reg.ar_rdy;
	assign rvalid  = s_reg.rvalid;
	assign rresp   = s_reg.rresp;
	assign rdata   = {24'h000000, s_reg.rdata};
	assign overflow_irq = s_reg.ovf_irq;
	assign external_clock_force_input = s_reg.ext_force;

	// counter clock: divider taps or rising edge of the external pin
	assign pmask    = ~(6'h3f << s_reg.ps);
	assign ext_rise = s_reg.ext_s2 & ~s_reg.ext_s3;
	assign tick     = ~s_reg.counter_stop & ((s_reg.ps == `PS_EXT) ? ext_rise
		: ((s_reg.presc & pmask) == pmask));
	assign wrap     = (s_reg.cnt == s_reg.mod);

	// per-channel strobes and pair wiring
	genvar i;
	generate
		for (i = 0; i < 4; i++)
		begin : g_ch
			localparam logic [7:0] BASE = 8'(`OFS_CH0_SC + i * `CH_STRIDE);
			assign chan[i].wr_sc  = wr_en & (s_reg.awaddr == BASE);
			assign chan[i].wr_hi  = wr_en & (s_reg.awaddr == BASE + `CH_HI);
			assign chan[i].wr_lo  = wr_en & (s_reg.awaddr == BASE + `CH_LO);
			assign chan[i].rd_sc  = rd_fire & (araddr == BASE);
			assign chan[i].rd_hi  = rd_fire & (araddr == BASE + `CH_HI);
			assign chan[i].rd_lo  = rd_fire & (araddr == BASE + `CH_LO);
			assign chan[i].wdata  = s_reg.wdata;
			assign chan[i].cnt    = s_reg.cnt;
			assign chan[i].step   = s_reg.step;
			assign chan[i].ovf    = s_reg.ovf;
			assign chan[i].pin_in = channel_pin_in[i];
			assign ch_sc[i] = chan[i].sc_rd;
			assign ch_hi[i] = chan[i].hi_rd;
			assign ch_lo[i] = chan[i].lo_rd;
			assign channel_pin_out[i] = chan[i].pin_out;
			assign channel_pin_oe[i]  = chan[i].pin_oe;
			assign channel_irq[i]     = chan[i].irq;
			if (i % 2 == 0)
			begin : g_even
				assign chan[i].linked_off  = 1'b0;
				assign chan[i].partner_val = chan[i + 1].val;
				assign chan[i].partner_wr  = chan[i + 1].wr_lo;
			end
			else
			begin : g_odd
				assign chan[i].linked_off  = chan[i - 1].buf_on;
				assign chan[i].partner_val = 16'h0000;
				assign chan[i].partner_wr  = 1'b0;
			end
			timer_channel #(
				.HAS_BUF (i % 2 == 0)
			) u_chan (
				.aclk    (aclk),
				.aresetn (aresetn),
				.bus     (chan[i])
			);
		end
	endgenerate

	// read mux; unmapped or misaligned addresses answer with slverr
	always_comb
	begin
		rmux    = 8'h00;
		rmapped = (araddr <= `OFS_LAST) && (araddr[1:0] == 2'h0);
		case (araddr)
			`OFS_TSC:    rmux = {s_reg.overflow_flag, s_reg.overflow_irq_enable, s_reg.counter_stop,
				2'h0, s_reg.ps};
			`OFS_CNT_HI: rmux = s_reg.cnt[15:8];
			`OFS_CNT_LO: rmux = s_reg.lo_held ? s_reg.lo_buf
				: s_reg.cnt[7:0];
			`OFS_MOD_HI: rmux = s_reg.mod[15:8];
			`OFS_MOD_LO: rmux = s_reg.mod[7:0];
			default:
			begin
				for (int k = 0; k < 4; k++)
				begin
					if (araddr == 8'(`OFS_CH0_SC + 8'(k) * `CH_STRIDE))
						rmux = ch_sc[k];
					if (araddr == 8'(`OFS_CH0_SC + 8'(k) * `CH_STRIDE + `CH_HI))
						rmux = ch_hi[k];
					if (araddr == 8'(`OFS_CH0_SC + 8'(k) * `CH_STRIDE + `CH_LO))
						rmux = ch_lo[k];
				end
			end
		endcase
	end

	// bus handshakes, counter and status updates
	always_comb
	begin
		s_next = s_reg;
		if (awvalid & s_reg.aw_rdy)
		begin
			s_next.aw_got = 1'b1;
			s_next.awaddr = awaddr;
			s_next.aw_rdy = 1'b0;
		end
		if (wvalid & s_reg.w_rdy)
		begin
			s_next.w_got  = 1'b1;
			s_next.wdata  = wdata[7:0];
			s_next.wstrb0 = wstrb[0];
			s_next.w_rdy  = 1'b0;
		end
		if (wr_fire)
		begin
			s_next.aw_got = 1'b0;
			s_next.w_got  = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp  = ((s_reg.awaddr <= `OFS_LAST)
				&& (s_reg.awaddr[1:0] == 2'h0)) ? `RESP_OKAY : `RESP_SLVERR;
		end
		// readies come back only after the response is taken
		if (s_reg.bvalid & bready)
		begin
			s_next.bvalid = 1'b0;
			s_next.aw_rdy = 1'b1;
			s_next.w_rdy  = 1'b1;
		end
		if (rd_fire)
		begin
			s_next.ar_rdy = 1'b0;
			s_next.rvalid = 1'b1;
			s_next.rdata  = rmux;
			s_next.rresp  = rmapped ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (s_reg.rvalid & rready)
		begin
			s_next.rvalid = 1'b0;
			s_next.ar_rdy = 1'b1;
		end

		// external pin: second flop feeds the edge detector
		s_next.ext_s1 = external_clock_pin;
		s_next.ext_s2 = s_reg.ext_s1;
		s_next.ext_s3 = s_reg.ext_s2;

		// prescaler runs only while the counter runs
		if (~s_reg.counter_stop)
			s_next.presc = s_reg.presc + 6'h01;
		s_next.step = tick;
		s_next.ovf  = tick & wrap;
		if (tick)
			s_next.cnt = wrap ? 16'h0000 : s_reg.cnt + 16'h0001;

		// latched low byte of the counter
		if (rd_fire & (araddr == `OFS_CNT_HI) & ~s_reg.lo_held)
		begin
			s_next.lo_buf  = s_reg.cnt[7:0];
			s_next.lo_held = 1'b1;
		end
		if (rd_fire & (araddr == `OFS_CNT_LO))
			s_next.lo_held = 1'b0;

		// overflow flag clearing sequence
		if (rd_fire & (araddr == `OFS_TSC) & s_reg.overflow_flag)
			s_next.tof_armed = 1'b1;
		if (wr_en & (s_reg.awaddr == `OFS_TSC))
		begin
			if (~s_reg.wdata[`TSC_FLAG] & s_reg.tof_armed)
				s_next.overflow_flag = 1'b0;
			s_next.tof_armed = 1'b0;
			s_next.overflow_irq_enable  = s_reg.wdata[`TSC_IE];
			s_next.counter_stop = s_reg.wdata[`TSC_STOP];
			s_next.ps    = s_reg.wdata[2:0];
			if (s_reg.wdata[`TSC_RST])
			begin
				s_next.cnt   = 16'h0000;
				s_next.presc = 6'h00;
				s_next.step  = 1'b0;
				s_next.ovf   = 1'b0;
			end
		end

		// modulo writes; high byte holds off the overflow flag
		if (wr_en & (s_reg.awaddr == `OFS_MOD_HI))
		begin
			s_next.mod[15:8] = s_reg.wdata;
			s_next.mod_block = 1'b1;
		end
		if (wr_en & (s_reg.awaddr == `OFS_MOD_LO))
		begin
			s_next.mod[7:0]  = s_reg.wdata;
			s_next.mod_block = 1'b0;
		end

		// an overflow beats a clear in the same cycle
		if (tick & wrap & ~s_reg.mod_block)
		begin
			s_next.overflow_flag       = 1'b1;
			s_next.tof_armed = 1'b0;
		end
		s_next.ovf_irq   = s_next.overflow_flag & s_next.overflow_irq_enable;
		s_next.ext_force = (s_next.ps == `PS_EXT);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_reg        <= '0;
			s_reg.counter_stop  <= 1'b1;
			s_reg.mod    <= `MOD_RST;
			s_reg.aw_rdy <= 1'b1;
			s_reg.w_rdy  <= 1'b1;
			s_reg.ar_rdy <= 1'b1;
		end
		else
			s_reg <= s_next;
	end
endmodule
`default_nettype wire

// ### testbench/timer_module_assertions.sv
// port-level checks of the timer block
`timescale 1ns/1ps
`default_nettype none
`include "timer_cfg.svh"
module timer_module_assertions (
	input wire logic               aclk,
	input wire logic               aresetn,
	input wire logic [`AXI_AW-1:0] awaddr,
	input wire logic               awvalid,
	input wire logic               awready,
	input wire logic               wready,
	input wire logic [1:0]         bresp,
	input wire logic               bvalid,
	input wire logic               bready,
	input wire logic [`AXI_AW-1:0] araddr,
	input wire logic               arvalid,
	input wire logic               arready,
	input wire logic [31:0]        rdata,
	input wire logic [1:0]         rresp,
	input wire logic               rvalid,
	input wire logic               rready,
	input wire logic               external_clock_force_input,
	input wire logic [3:0]         channel_pin_oe,
	input wire logic               overflow_irq,
	input wire logic [3:0]         channel_irq
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// register effects land with the write response, or one cycle later
	sequence write_landing;
		bvalid || $past(bvalid);
	endsequence
	sequence read_taken;
		arvalid && arready;
	endsequence
	sequence bad_read;
		read_taken ##0 (araddr > `OFS_LAST || araddr[1:0] != 2'h0);
	endsequence

	// bus handshake holds and refusals
	a_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped early");
	a_rvalid_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped early");
	a_read_answer: assert property (read_taken |=> rvalid)
		else $error("read not answered next cycle");
	a_write_refused: assert property (bvalid |-> !awready && !wready)
		else $error("write taken while response pending");
	a_read_unmapped: assert property (bad_read |=> rresp == `RESP_SLVERR && rdata == 32'h0)
		else $error("unmapped read not refused");
	a_write_unmapped: assert property (awvalid && awready && awaddr > `OFS_LAST
		|-> ##[1:40] bvalid && bresp == `RESP_SLVERR)
		else $error("unmapped write not refused");
	// outputs only configuration may change, and requests only a clearing write may drop
	a_force_input: assert property ($changed(external_clock_force_input) |-> write_landing)
		else $error("pin direction changed without a write");
	a_ovf_irq_clear: assert property ($fell(overflow_irq) |-> write_landing)
		else $error("overflow request fell without a write");
	a_chan_irq_clear: assert property (|($past(channel_irq) & ~channel_irq) |-> write_landing)
		else $error("channel request fell without a write");
	a_pin_oe_config: assert property ($changed(channel_pin_oe) |-> write_landing)
		else $error("pin enable changed without a write");
endmodule

bind timer_module timer_module_assertions checker_inst (
	.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
	.awready(awready), .wready(wready), .bresp(bresp), .bvalid(bvalid),
	.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
	.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
	.external_clock_force_input(external_clock_force_input),
	.channel_pin_oe(channel_pin_oe), .overflow_irq(overflow_irq),
	.channel_irq(channel_irq)
);
`default_nettype wire

// ### testbench/ext_clock_source.sv
// external count clock source: bursts of whole pulses, idle low
`timescale 1ns/1ps
`default_nettype none
module ext_clock_source (
	input  wire logic       aclk,
	input  wire logic       go,
	input  wire logic [7:0] count,
	output logic            pin
);
	logic [9:0] phase_reg = 10'h0;

	// two cycles high, two low: well under half the bus rate
	always_ff @(posedge aclk)
	begin
		if (go)
			phase_reg <= {count, 2'b00};
		else if (phase_reg != 10'h0)
			phase_reg <= phase_reg - 10'h1;
	end
	// stands still low between bursts
	assign pin = phase_reg[1];
endmodule
`default_nettype wire

// ### testbench/four_channel_timer_module_bench.sv
// register-level self-checking bench of the timer block
`timescale 1ns/1ps
`default_nettype none
`include "timer_cfg.svh"
module four_channel_timer_module_bench;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, force_in;
	logic        ovf_irq, go, ext_pin;
	logic [7:0]  awaddr, araddr, cnt8, rd, count;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp, resp;
	logic [3:0]  pin_in, pin_out, pin_oe, ch_irq;
	int          n_errors, compares, cycles;

	timer_module dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(4'h1), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .external_clock_pin(ext_pin),
		.external_clock_force_input(force_in), .channel_pin_in(pin_in),
		.channel_pin_out(pin_out), .channel_pin_oe(pin_oe),
		.overflow_irq(ovf_irq), .channel_irq(ch_irq));
	ext_clock_source source (.aclk(aclk), .go(go), .count(count), .pin(ext_pin));

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_rng(input logic [7:0] got, input int lo, input int hi);
		compares++;
		if ($isunknown(got) || got < lo || got > hi)
		begin
			n_errors++;
			$display("ERROR %0t: got %h outside %0d..%0d", $time, got, lo, hi);
		end
	endtask
	// samples are taken on falling edges, so never race the design
	task automatic tick(input int n);
		repeat (n) @(negedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ta, tw, tb;
		@(posedge aclk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		tb = 1'b0;
		while (!tb)
		begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid;
			resp = bresp;
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
		tick(2);
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		logic ta, tr;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		tr = 1'b0;
		while (!tr)
		begin
			@(negedge aclk);
			ta = arvalid & arready;
			tr = rvalid;
			d = rdata[7:0];
			resp = rresp;
			@(posedge aclk);
			if (ta)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		rd_reg(a, rd);
		chk(rd, exp);
	endtask

	// clock and hang guard
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	always @(posedge aclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			n_errors++;
			$display("ERROR %0t: run did not finish", $time);
			complete_run();
		end
	end

	initial
	begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, go} = 7'h0;
		{awaddr, araddr, wdata, pin_in, count} = 0;
		{n_errors, compares, cycles} = 0;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(`OFS_TSC, 8'h20);
		rchk(`OFS_MOD_HI, 8'hff);
		rchk(`OFS_MOD_LO, 8'hff);
		rchk(`OFS_CNT_LO, 8'h00);
		rchk(`OFS_CH0_SC, 8'h00);
		$display("reset values done");
		wr(`OFS_MOD_HI, 8'h00);
		wr(`OFS_MOD_LO, 8'h0f);
		wr(`OFS_TSC, 8'h50);
		tick(40);
		chk({7'h0, ovf_irq}, 8'h01);
		rchk(`OFS_TSC, 8'hc0);
		tick(20);
		wr(`OFS_TSC, 8'h40);
		wr(`OFS_TSC, 8'h60);
		rchk(`OFS_TSC, 8'he0);
		wr(`OFS_TSC, 8'h60);
		chk({7'h0, ovf_irq}, 8'h00);
		wr(`OFS_TSC, 8'he0);
		rchk(`OFS_TSC, 8'h60);
		rchk(`OFS_CNT_HI, 8'h00);
		rd_reg(`OFS_CNT_LO, rd);
		chk_rng(rd, 0, 15);
		$display("overflow flag done");
		wr(`OFS_TSC, 8'h30);
		wr(`OFS_MOD_HI, 8'h00);
		wr(`OFS_TSC, 8'h10);
		tick(40);
		wr(`OFS_TSC, 8'h20);
		rchk(`OFS_TSC, 8'h20);
		wr(`OFS_MOD_LO, 8'h0f);
		wr(`OFS_TSC, 8'h10);
		tick(40);
		wr(`OFS_TSC, 8'h20);
		rchk(`OFS_TSC, 8'ha0);
		wr(`OFS_TSC, 8'h20);
		wr(`OFS_TSC, 8'h30);
		rchk(`OFS_CNT_HI, 8'h00);
		rchk(`OFS_CNT_LO, 8'h00);
		rchk(`OFS_TSC, 8'h20);
		rchk(`OFS_MOD_LO, 8'h0f);
		$display("modulo and stop done");
		wr(`OFS_MOD_HI, 8'hff);
		wr(`OFS_MOD_LO, 8'hff);
		wr(`OFS_TSC, 8'h10);
		rd_reg(`OFS_CNT_HI, rd);
		tick(50);
		wr(`OFS_TSC, 8'h20);
		rd_reg(`OFS_CNT_LO, cnt8);
		rd_reg(`OFS_CNT_HI, rd);
		rd_reg(`OFS_CNT_LO, rd);
		chk_rng(rd - cnt8, 50, 70);
		for (int p = 0; p < 7; p++)
		begin
			wr(`OFS_TSC, 8'h30 | 8'(p));
			wr(`OFS_TSC, 8'h10 | 8'(p));
			tick(128);
			wr(`OFS_TSC, 8'h20 | 8'(p));
			rd_reg(`OFS_CNT_LO, rd);
			chk_rng(rd, 128 >> p, (141 >> p) + 1);
		end
		$display("latch and prescaler done");
		wr(`OFS_TSC, 8'h37);
		wr(`OFS_TSC, 8'h17);
		chk({7'h0, force_in}, 8'h01);
		@(posedge aclk);
		count <= 8'h05;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
		tick(30);
		wr(`OFS_TSC, 8'h27);
		rchk(`OFS_CNT_LO, 8'h05);
		wr(`OFS_TSC, 8'h20);
		chk({7'h0, force_in}, 8'h00);
		$display("external clock done");
		wr(`OFS_CH0_SC, 8'h44);
		@(posedge aclk);
		pin_in <= 4'h1;
		tick(6);
		chk({4'h0, ch_irq}, 8'h01);
		rchk(`OFS_CH0_SC, 8'hc4);
		wr(`OFS_CH0_SC, 8'h44);
		chk({4'h0, ch_irq}, 8'h00);
		rchk(`OFS_CH0_SC, 8'h44);
		// value high read holds off captures until the low read
		rd_reg(8'h18, rd);
		@(posedge aclk);
		pin_in <= 4'h0;
		tick(2);
		@(posedge aclk);
		pin_in <= 4'h1;
		tick(4);
		chk({4'h0, ch_irq}, 8'h00);
		rd_reg(8'h1c, rd);
		@(posedge aclk);
		pin_in <= 4'h0;
		tick(2);
		@(posedge aclk);
		pin_in <= 4'h1;
		tick(4);
		chk({4'h0, ch_irq}, 8'h01);
		wr(8'h2c, 8'h18);
		chk({4'h0, pin_oe}, 8'h04);
		wr(8'h30, 8'h00);
		wr(8'h34, 8'h05);
		wr(`OFS_TSC, 8'h10);
		tick(20);
		chk({7'h0, pin_out[2]}, 8'h00);
		wr(`OFS_TSC, 8'h20);
		rchk(8'h2c, 8'h98);
		wr(8'h2c, 8'h00);
		chk({4'h0, pin_oe}, 8'h00);
		wr(8'h38, 8'h10);
		chk({7'h0, pin_out[3]}, 8'h00);
		wr(8'h38, 8'h00);
		chk({7'h0, pin_out[3]}, 8'h01);
		$display("capture and compare done");
		wr(8'h20, 8'h3c);
		chk({4'h0, pin_oe}, 8'h02);
		rchk(8'h20, 8'h1c);
		wr(`OFS_CH0_SC, 8'h28);
		chk({4'h0, pin_oe}, 8'h01);
		wr(`OFS_CH0_SC, 8'h1d);
		chk({7'h0, pin_out[0]}, 8'h00);
		wr(`OFS_CH0_SC, 8'h19);
		chk({7'h0, pin_out[0]}, 8'h01);
		rd_reg(8'h44, rd);
		chk({6'h0, resp}, 8'h02);
		wr(8'h05, 8'h00);
		chk({6'h0, resp}, 8'h02);
		wr(8'h48, 8'h00);
		chk({6'h0, resp}, 8'h02);
		$display("buffered, duty and unmapped done");
		complete_run();
	end
endmodule
`default_nettype wire
